/* hw/mrs_core.sv */
// Purpose: Run/stop decoding, operation data selection and torque limit scaling
// Assumes: Controller holds pins steady and respects reversal gaps
// Notes:   Voltage input is volts times 256, unsigned, 0 to 2560
// Notes on behaviour
// - Torque limit comes from analog voltage or stored data, per selection setting.
// - Analog torque limit is gain percent per volt times voltage, default 40.
// - Analog torque limit is clamped to a maximum 0 to 200, default 200.
// - A signed offset of -50 to 50 percent, default 0, is added.
// - Forward input alone runs clockwise; releasing it stops the motor.
// - Reverse input alone runs counterclockwise; releasing it stops the motor.
// - Forward and reverse together stop the motor instantly.
// - Stop decelerates with stop-mode input on, stops instantly with it off.
// - Four select inputs index one of 16 operation data sets.
// - With three select inputs assigned, top select bit reads as zero.
// - Stored torque used unless analog selection is torque; stored speed always drives speed_cmd.
// - Analog speed mode uses ramp times of data set zero.
`timescale 1ns/1ps
module mrs_core
  import mrs_pkg::*;
#(
  parameter int QUAL_CYCLES = MRS_QUAL_CYC,
  parameter int SETS        = 16
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Register bus
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Control pins
  input  wire logic        forward_run_input,
  input  wire logic        reverse_run_input,
  input  wire logic        stop_mode_input,
  input  wire logic [3:0]  speed_set_select_inputs,
  input  wire logic [11:0] torque_volt,
  // Motor command
  output logic             motor_run,
  output logic             motor_cw,
  output logic             motor_decel,
  output logic             motor_brake,
  output logic      [11:0] speed_cmd,
  output logic             speed_analog,
  output logic      [7:0]  accel_time,
  output logic      [7:0]  decel_time,
  output logic      [7:0]  torque_limit,
  output logic      [3:0]  data_index
);

  // Qualified pin levels
  logic       run_cw_lvl;
  logic       run_ccw_lvl;
  logic       stop_lvl;
  logic [3:0] sel_lvl;

  mrs_in_filter #(.CNT_W(MRS_QUAL_W), .QUAL_CYCLES(QUAL_CYCLES)) u_run_cw (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     (forward_run_input),
    .level   (run_cw_lvl)
  );

  mrs_in_filter #(.CNT_W(MRS_QUAL_W), .QUAL_CYCLES(QUAL_CYCLES)) u_run_ccw (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     (reverse_run_input),
    .level   (run_ccw_lvl)
  );

  mrs_in_filter #(.CNT_W(MRS_QUAL_W), .QUAL_CYCLES(QUAL_CYCLES)) u_stop (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     (stop_mode_input),
    .level   (stop_lvl)
  );

  for (genvar i = 0; i < 4; i++) begin : g_sel
    mrs_in_filter #(.CNT_W(MRS_QUAL_W), .QUAL_CYCLES(QUAL_CYCLES)) u_sel (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin     (speed_set_select_inputs[i]),
      .level   (sel_lvl[i])
    );
  end

  // Voltage synchroniser; a word is taken once two samples agree
  logic [11:0] volt_s1_q;
  logic [11:0] volt_s2_q;
  logic [11:0] volt_s3_q;
  logic [11:0] volt_q;

  wire volt_steady = volt_s2_q == volt_s3_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      volt_s1_q <= '0;
      volt_s2_q <= '0;
      volt_s3_q <= '0;
      volt_q    <= '0;
    end else begin
      volt_s1_q <= torque_volt;
      volt_s2_q <= volt_s1_q;
      volt_s3_q <= volt_s2_q;
      if (volt_steady) volt_q <= volt_s2_q;
    end
  end

  // Configuration registers
  logic [1:0]  an_sel_q;
  logic        sel_w4_q;
  logic [7:0]  gain_q;
  logic [7:0]  tq_max_q;
  logic [7:0]  offs_q;
  logic [11:0] spd_mem_q [SETS];
  logic [7:0]  acc_mem_q [SETS];
  logic [7:0]  dec_mem_q [SETS];
  logic [7:0]  tq_mem_q  [SETS];

  // Address decode
  wire       hit_cfg  = addr == MRS_CFG_OFS;
  wire       hit_gain = addr == MRS_GAIN_OFS;
  wire       hit_max  = addr == MRS_MAX_OFS;
  wire       hit_offs = addr == MRS_OFFS_OFS;
  wire       hit_stat = addr == MRS_STAT_OFS;
  wire       hit_data = (addr >= MRS_DATA_BASE) && (addr < MRS_DATA_LIMIT)
                        && (addr[1:0] == 2'b00);
  wire [1:0] d_fld    = addr[7:6];
  wire [3:0] d_idx    = addr[5:2];

  // Written values held inside their ranges
  wire [7:0] wr_max  = (wdata[7:0] > MRS_MAX_LIM) ? MRS_MAX_LIM : wdata[7:0];
  wire       offs_hi = !wdata[7] && (wdata[7:0] > MRS_OFFS_HI);
  wire       offs_lo = wdata[7] && (wdata[7:0] < MRS_OFFS_LO);
  wire [7:0] wr_offs = offs_hi ? MRS_OFFS_HI : (offs_lo ? MRS_OFFS_LO : wdata[7:0]);
  wire [7:0] wr_tq   = (wdata[7:0] > MRS_MAX_LIM) ? MRS_MAX_LIM : wdata[7:0];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      an_sel_q <= MRS_AN_RST;
      sel_w4_q <= MRS_W4_RST;
      gain_q   <= MRS_GAIN_RST;
      tq_max_q <= MRS_MAX_RST;
      offs_q   <= MRS_OFFS_RST;
    end else if (wr) begin
      if (hit_cfg) begin
        an_sel_q <= wdata[MRS_CFG_SEL_LSB +: 2];
        sel_w4_q <= wdata[MRS_CFG_W4_BIT];
      end
      if (hit_gain) gain_q <= wdata[7:0];
      if (hit_max) tq_max_q <= wr_max;
      if (hit_offs) offs_q <= wr_offs;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int k = 0; k < SETS; k++) begin
        spd_mem_q[k] <= MRS_SPEED_RST;
        acc_mem_q[k] <= MRS_RAMP_RST;
        dec_mem_q[k] <= MRS_RAMP_RST;
        tq_mem_q[k]  <= MRS_TQ_RST;
      end
    end else if (wr && hit_data) begin
      if (d_fld == MRS_FLD_SPEED) spd_mem_q[d_idx] <= wdata[11:0];
      if (d_fld == MRS_FLD_ACC) acc_mem_q[d_idx] <= wdata[7:0];
      if (d_fld == MRS_FLD_DEC) dec_mem_q[d_idx] <= wdata[7:0];
      if (d_fld == MRS_FLD_TQ) tq_mem_q[d_idx] <= wr_tq;
    end
  end

  // Motion state machine
  mrs_state_e state_q;
  mrs_state_e state_d;

  wire moving = (state_q == MRS_ST_CW) || (state_q == MRS_ST_CCW);

  always_comb begin
    state_d = state_q;
    case (1'b1)
      run_cw_lvl && run_ccw_lvl: state_d = MRS_ST_BRAKE;
      run_cw_lvl:                state_d = MRS_ST_CW;
      run_ccw_lvl:               state_d = MRS_ST_CCW;
      default: begin
        case (state_q)
          MRS_ST_CW, MRS_ST_CCW: state_d = stop_lvl ? MRS_ST_DECEL : MRS_ST_BRAKE;
          MRS_ST_BRAKE:          state_d = MRS_ST_IDLE;
          default:               state_d = state_q;
        endcase
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) state_q <= MRS_ST_IDLE;
    else state_q <= state_d;
  end

  // Operation data selection
  wire [3:0]  idx_sel  = sel_w4_q ? sel_lvl : {1'b0, sel_lvl[2:0]};
  wire        an_speed = an_sel_q == MRS_AN_SPEED;
  wire        an_tq    = an_sel_q == MRS_AN_TORQUE;
  wire [3:0]  ramp_idx = an_speed ? 4'h0 : idx_sel;

  // Analog torque scaling
  wire [19:0]        tq_prod = gain_q * volt_q;
  wire [11:0]        tq_pct  = tq_prod[19:8];
  wire signed [13:0] tq_sum  = $signed({2'b00, tq_pct})
                               + $signed({{6{offs_q[7]}}, offs_q});
  wire               tq_neg  = tq_sum[13];
  wire               tq_big  = !tq_neg && (tq_sum[12:0] > {5'h00, tq_max_q});
  wire [7:0]         tq_an   = tq_neg ? 8'h00 : (tq_big ? tq_max_q : tq_sum[7:0]);
  wire [7:0]         tq_d    = an_tq ? tq_an : tq_mem_q[idx_sel];

  // Command registers
  logic        run_q;
  logic        cw_q;
  logic        decel_q;
  logic        brake_q;
  logic [11:0] speed_q;
  logic        spd_an_q;
  logic [7:0]  acc_q;
  logic [7:0]  dec_q;
  logic [7:0]  tq_lim_q;
  logic [3:0]  idx_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      run_q    <= 1'b0;
      cw_q     <= 1'b0;
      decel_q  <= 1'b0;
      brake_q  <= 1'b0;
      speed_q  <= MRS_SPEED_RST;
      spd_an_q <= 1'b0;
      acc_q    <= MRS_RAMP_RST;
      dec_q    <= MRS_RAMP_RST;
      tq_lim_q <= MRS_TQ_RST;
      idx_q    <= 4'h0;
    end else begin
      run_q    <= (state_d == MRS_ST_CW) || (state_d == MRS_ST_CCW);
      cw_q     <= state_d == MRS_ST_CW;
      decel_q  <= state_d == MRS_ST_DECEL;
      brake_q  <= state_d == MRS_ST_BRAKE;
      speed_q  <= spd_mem_q[idx_sel];
      spd_an_q <= an_speed;
      acc_q    <= acc_mem_q[ramp_idx];
      dec_q    <= dec_mem_q[ramp_idx];
      tq_lim_q <= tq_d;
      idx_q    <= idx_sel;
    end
  end

  // Read data, one cycle after the strobe
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;

  wire [31:0] stat_word = {8'h00, tq_lim_q, 4'h0, idx_q, 3'h0, state_q};
  wire [31:0] data_word = (d_fld == MRS_FLD_SPEED) ? {20'h0, spd_mem_q[d_idx]} :
                          (d_fld == MRS_FLD_ACC)   ? {24'h0, acc_mem_q[d_idx]} :
                          (d_fld == MRS_FLD_DEC)   ? {24'h0, dec_mem_q[d_idx]} :
                                                     {24'h0, tq_mem_q[d_idx]};

  always_comb begin
    if (hit_cfg) rd_mux = {29'h0, sel_w4_q, an_sel_q};
    else if (hit_gain) rd_mux = {24'h0, gain_q};
    else if (hit_max) rd_mux = {24'h0, tq_max_q};
    else if (hit_offs) rd_mux = {24'h0, offs_q};
    else if (hit_stat) rd_mux = stat_word;
    else if (hit_data) rd_mux = data_word;
    else rd_mux = 32'h0;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) rdata_q <= 32'h0;
    else if (rd) rdata_q <= rd_mux;
    else rdata_q <= 32'h0;
  end

  assign rdata        = rdata_q;
  assign motor_run    = run_q;
  assign motor_cw     = cw_q;
  assign motor_decel  = decel_q;
  assign motor_brake  = brake_q;
  assign speed_cmd    = speed_q;
  assign speed_analog = spd_an_q;
  assign accel_time   = acc_q;
  assign decel_time   = dec_q;
  assign torque_limit = tq_lim_q;
  assign data_index   = idx_q;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_both_brake: assert property (
    run_cw_lvl && run_ccw_lvl |=> motor_brake && !motor_run && state_q == MRS_ST_BRAKE)
    else $error("both directions did not brake");

  a_cw_alone_runs: assert property (
    run_cw_lvl && !run_ccw_lvl |=> motor_run && motor_cw)
    else $error("forward alone did not run clockwise");

  a_ccw_alone_runs: assert property (
    run_ccw_lvl && !run_cw_lvl |=> motor_run && !motor_cw)
    else $error("reverse alone did not run counterclockwise");

  a_stop_ramp: assert property (
    moving && !run_cw_lvl && !run_ccw_lvl && stop_lvl
      |=> motor_decel ##1 (motor_decel || run_cw_lvl || run_ccw_lvl))
    else $error("stop with stop mode did not decelerate");

  a_stop_instant: assert property (
    moving && !run_cw_lvl && !run_ccw_lvl && !stop_lvl |=> motor_brake && !motor_run)
    else $error("stop without stop mode was not instant");

  a_tq_clamp: assert property (
    an_tq |=> torque_limit <= $past(tq_max_q))
    else $error("analog torque limit above maximum");

  a_tq_floor: assert property (
    an_tq && tq_neg |=> torque_limit == 8'h00)
    else $error("negative torque command not held at zero");

  a_tq_scale: assert property (
    an_tq && offs_q == 8'h00 && tq_pct <= {4'h0, tq_max_q} |=> torque_limit == $past(tq_pct[7:0]))
    else $error("torque limit not gain times voltage");

  a_tq_digital: assert property (
    !an_tq |=> torque_limit == $past(tq_mem_q[idx_sel]))
    else $error("digital torque limit not taken from data set");

  a_idx_narrow: assert property (
    !sel_w4_q |=> !data_index[3])
    else $error("top select bit used in narrow mode");

  a_ramp_set0: assert property (
    an_speed |=> accel_time == $past(acc_mem_q[0]) && decel_time == $past(dec_mem_q[0]))
    else $error("analog speed mode ramps not from set zero");

  c_run_cw: cover property (run_cw_lvl && !run_ccw_lvl ##1 motor_run && motor_cw);
  c_run_ccw: cover property (run_ccw_lvl && !run_cw_lvl ##1 motor_run && !motor_cw);
  c_decel: cover property (motor_run ##1 motor_decel);
  c_brake_both: cover property (motor_run ##1 run_cw_lvl && run_ccw_lvl ##1 motor_brake);

endmodule

/* hw/mrs_in_filter.sv */
// Purpose: Synchronise one control pin and accept a new level once stable
// Assumes: Pin is asynchronous to sys_clk
// Notes:   Level changes only after QUAL_CYCLES steady samples
`timescale 1ns/1ps
module mrs_in_filter
  import mrs_pkg::*;
#(
  parameter int CNT_W       = MRS_QUAL_W,
  parameter int QUAL_CYCLES = MRS_QUAL_CYC
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Pin and qualified level
  input  wire logic pin,
  output logic      level
);

  logic             s1_q;
  logic             s2_q;
  logic             lvl_q;
  logic [CNT_W-1:0] cnt_q;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(QUAL_CYCLES - 1);

  wire differs = s2_q != lvl_q;
  wire settled = differs && (cnt_q >= LAST);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
      lvl_q <= 1'b0;
    end else if (!differs || settled) begin
      cnt_q <= '0;
      lvl_q <= s2_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign level = lvl_q;

endmodule

/* hw/mrs_pkg.sv */
// Purpose: Shared constants for the motor run/stop and torque-limit block
// Assumes: 250 MHz system clock, register bus with 12-bit byte address
// Notes:   Operation data words sit at base + field * 0x40 + index * 4
package mrs_pkg;

  // Clock and input qualification time
  localparam longint MRS_CLK_HZ       = 250_000_000;
  localparam int     MRS_QUAL_TIME_MS = 10;
  localparam int     MRS_QUAL_CYC     = int'((MRS_CLK_HZ / 1000) * MRS_QUAL_TIME_MS);
  localparam int     MRS_QUAL_W       = 22;

  // Register offsets
  localparam logic [11:0] MRS_CFG_OFS    = 12'h000;
  localparam logic [11:0] MRS_GAIN_OFS   = 12'h004;
  localparam logic [11:0] MRS_MAX_OFS    = 12'h008;
  localparam logic [11:0] MRS_OFFS_OFS   = 12'h00c;
  localparam logic [11:0] MRS_STAT_OFS   = 12'h010;
  localparam logic [11:0] MRS_DATA_BASE  = 12'h100;
  localparam logic [11:0] MRS_DATA_LIMIT = 12'h200;

  // Operation data fields
  localparam logic [1:0] MRS_FLD_SPEED = 2'h0;
  localparam logic [1:0] MRS_FLD_ACC   = 2'h1;
  localparam logic [1:0] MRS_FLD_DEC   = 2'h2;
  localparam logic [1:0] MRS_FLD_TQ    = 2'h3;

  // Config field positions
  localparam int MRS_CFG_SEL_LSB = 0;
  localparam int MRS_CFG_W4_BIT  = 2;

  // Analog input selection codes
  localparam logic [1:0] MRS_AN_OFF    = 2'h0;
  localparam logic [1:0] MRS_AN_SPEED  = 2'h1;
  localparam logic [1:0] MRS_AN_TORQUE = 2'h2;

  // Reset values and limits
  localparam logic [1:0]  MRS_AN_RST     = 2'h1;
  localparam logic        MRS_W4_RST     = 1'b1;
  localparam logic [7:0]  MRS_GAIN_RST   = 8'h28;
  localparam logic [7:0]  MRS_MAX_RST    = 8'hc8;
  localparam logic [7:0]  MRS_MAX_LIM    = 8'hc8;
  localparam logic [7:0]  MRS_OFFS_RST   = 8'h00;
  localparam logic [7:0]  MRS_OFFS_HI    = 8'h32;
  localparam logic [7:0]  MRS_OFFS_LO    = 8'hce;
  localparam logic [11:0] MRS_SPEED_RST  = 12'h000;
  localparam logic [7:0]  MRS_RAMP_RST   = 8'h05;
  localparam logic [7:0]  MRS_TQ_RST     = 8'hc8;

  // Motion states, one-hot
  typedef enum logic [4:0] {
    MRS_ST_IDLE  = 5'b00001,
    MRS_ST_CW    = 5'b00010,
    MRS_ST_CCW   = 5'b00100,
    MRS_ST_DECEL = 5'b01000,
    MRS_ST_BRAKE = 5'b10000
  } mrs_state_e;

endpackage

/* verif/mrs_ctrl_model.sv */
// Purpose: Controller model driving run, stop-mode and select pins
// Assumes: Pins change by non-blocking assignment on a rising edge
// Notes:   Every level stands HOLD cycles; reversal inserts a released gap
`timescale 1ns/1ps
module mrs_ctrl_model #(
  parameter int HOLD = 16
) (
  // Clock
  input  wire logic       sys_clk,
  // Control pins
  output logic            cw_pin,
  output logic            ccw_pin,
  output logic            stop_mode,
  output logic      [3:0] sel
);
  int cyc      = 0;
  int last_chg = 0;

  initial begin
    cw_pin    = 1'b0;
    ccw_pin   = 1'b0;
    stop_mode = 1'b0;
    sel       = 4'h0;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
  end

  // Keep the present level long enough to be registered
  task automatic hold_level();
    while (cyc - last_chg < HOLD) begin
      @(posedge sys_clk);
    end
  endtask

  task automatic set_pins(input logic f, input logic r, input logic s, input logic [3:0] m);
    @(posedge sys_clk);
    hold_level();
    if ((cw_pin && r && !f) || (ccw_pin && f && !r)) begin
      cw_pin   <= 1'b0;
      ccw_pin  <= 1'b0;
      last_chg = cyc;
      @(posedge sys_clk);
      hold_level();
    end
    cw_pin    <= f;
    ccw_pin   <= r;
    stop_mode <= s;
    sel       <= m;
    last_chg  = cyc;
  endtask
endmodule

/* verif/tb_mrs_core.sv */
// Purpose: Self-checking bench for run/stop, data selection and torque scaling
// Assumes: Register bus with one-cycle strobes, read data in the next cycle
// Notes:   Short qualification count keeps the run brief
`timescale 1ns/1ps
module tb_mrs_core;
  import mrs_pkg::*;
  localparam int QUAL = 8;
  localparam int HOLD = QUAL + 8;

  logic        sys_clk     = 1'b0;
  logic        rst         = 1'b1;
  logic [11:0] addr        = 12'h000;
  logic [31:0] wdata       = 32'h0;
  logic        wr          = 1'b0;
  logic        rd          = 1'b0;
  logic [11:0] torque_volt = 12'h000;
  logic [31:0] rdata;
  logic        cw_pin;
  logic        ccw_pin;
  logic        stop_mode;
  logic [3:0]  sel;
  logic        motor_run;
  logic        motor_cw;
  logic        motor_decel;
  logic        motor_brake;
  logic        speed_analog;
  logic [11:0] speed_cmd;
  logic [7:0]  accel_time;
  logic [7:0]  decel_time;
  logic [7:0]  torque_limit;
  logic [3:0]  data_index;
  int          fails   = 0;
  int          checked = 0;
  logic [0:4]  pf      = 5'b10001;
  logic [0:4]  pr      = 5'b00101;
  logic [0:4]  ps      = 5'b11001;
  logic [3:0]  pe [5]  = '{4'hc, 4'h2, 4'h8, 4'h1, 4'h1};
  int          tg [6]  = '{40, 20, 40, 40, 10, 40};
  int          tm [6]  = '{200, 200, 100, 200, 200, 255};
  int          to [6]  = '{0, 0, 0, -20, 100, -50};
  int          tv [6]  = '{1280, 2560, 2560, 0, 512, 2560};

  mrs_core #(.QUAL_CYCLES(QUAL), .SETS(16)) mrs_core_inst (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .forward_run_input(cw_pin), .reverse_run_input(ccw_pin),
    .stop_mode_input(stop_mode), .speed_set_select_inputs(sel), .torque_volt(torque_volt),
    .motor_run(motor_run), .motor_cw(motor_cw), .motor_decel(motor_decel),
    .motor_brake(motor_brake), .speed_cmd(speed_cmd), .speed_analog(speed_analog),
    .accel_time(accel_time), .decel_time(decel_time), .torque_limit(torque_limit),
    .data_index(data_index)
  );

  mrs_ctrl_model #(.HOLD(HOLD)) mrs_ctrl_model_inst (
    .sys_clk(sys_clk), .cw_pin(cw_pin), .ccw_pin(ccw_pin), .stop_mode(stop_mode), .sel(sel)
  );

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1;
    check(name, rdata, exp);
  endtask

  // Data word address from field and set index
  function automatic logic [11:0] dad(input logic [1:0] f, input logic [3:0] i);
    return MRS_DATA_BASE + 12'(f) * 12'h040 + 12'(i) * 12'h004;
  endfunction

  function automatic logic [7:0] exp_tq(input int g, input int mx, input int off, input int v);
    int s;
    s = (g * v) / 256 + off;
    if (s < 0) s = 0;
    if (s > mx) s = mx;
    return s[7:0];
  endfunction

  task automatic wait_motor(input logic [3:0] exp);
    int n;
    logic [3:0] seen;
    n = 0;
    while ({motor_run, motor_cw, motor_decel, motor_brake} !== exp && n < 4 * HOLD) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    seen = {motor_run, motor_cw, motor_decel, motor_brake};
    check("motor", {28'h0, seen}, {28'h0, exp});
    if (seen !== exp) end_sim();
  endtask

  initial begin
    int mx;
    int of;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk("cfg", MRS_CFG_OFS, 32'h5);
    rd_chk("gain", MRS_GAIN_OFS, 32'h28);
    rd_chk("max", MRS_MAX_OFS, 32'hc8);
    rd_chk("offset", MRS_OFFS_OFS, 32'h0);
    rd_chk("set torque", dad(MRS_FLD_TQ, 4'h9), 32'hc8);
    rd_chk("unmapped", 12'h020, 32'h0);
    check("torque reset", {24'h0, torque_limit}, 32'hc8);
    // Run, stop on ramp, reverse, instant stop, both pins
    for (int i = 0; i < 5; i++) begin
      mrs_ctrl_model_inst.set_pins(pf[i], pr[i], ps[i], 4'h0);
      wait_motor(pe[i]);
    end
    repeat (8) @(posedge sys_clk);
    #1;
    check("brake held", {31'h0, motor_brake & ~motor_decel}, 32'h1);
    rd_chk("status", MRS_STAT_OFS, 32'h00c80010);
    // Stored data selection
    wr_reg(dad(MRS_FLD_SPEED, 4'h3), 32'h123);
    wr_reg(dad(MRS_FLD_ACC, 4'h3), 32'h22);
    wr_reg(dad(MRS_FLD_DEC, 4'h3), 32'h33);
    wr_reg(dad(MRS_FLD_TQ, 4'h3), 32'h50);
    wr_reg(dad(MRS_FLD_ACC, 4'h0), 32'h11);
    wr_reg(MRS_CFG_OFS, 32'h4);
    mrs_ctrl_model_inst.set_pins(1'b0, 1'b0, 1'b0, 4'h3);
    repeat (HOLD) @(posedge sys_clk);
    #1;
    check("index", {28'h0, data_index}, 32'h3);
    check("speed", {20'h0, speed_cmd}, 32'h123);
    check("ramps", {16'h0, accel_time, decel_time}, 32'h2233);
    check("torque set", {24'h0, torque_limit}, 32'h50);
    check("analog", {31'h0, speed_analog}, 32'h0);
    wr_reg(MRS_CFG_OFS, 32'h5);
    repeat (2) @(posedge sys_clk);
    #1;
    check("accel set0", {24'h0, accel_time}, 32'h11);
    check("analog", {31'h0, speed_analog}, 32'h1);
    mrs_ctrl_model_inst.set_pins(1'b0, 1'b0, 1'b0, 4'hb);
    repeat (HOLD) @(posedge sys_clk);
    #1;
    check("index 16", {28'h0, data_index}, 32'hb);
    wr_reg(MRS_CFG_OFS, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1;
    check("index 8", {28'h0, data_index}, 32'h3);
    // Analog torque scaling
    wr_reg(MRS_CFG_OFS, 32'h6);
    for (int i = 0; i < 6; i++) begin
      mx = (tm[i] > 200) ? 200 : tm[i];
      of = (to[i] > 50) ? 50 : ((to[i] < -50) ? -50 : to[i]);
      wr_reg(MRS_GAIN_OFS, 32'(tg[i]));
      torque_volt <= 12'(tv[i]);
      wr_reg(MRS_MAX_OFS, 32'(tm[i]));
      wr_reg(MRS_OFFS_OFS, {24'h0, 8'(to[i])});
      rd_chk("max", MRS_MAX_OFS, 32'(mx));
      rd_chk("offset", MRS_OFFS_OFS, {24'h0, 8'(of)});
      check("torque", {24'h0, torque_limit}, {24'h0, exp_tq(tg[i], mx, of, tv[i])});
    end
    end_sim();
  end

  initial begin
    #400_000;
    fails++;
    end_sim();
  end
endmodule
